// file: psdp_defines.vh
// constants shared by the pipelined sram data port design files
`ifndef PSDP_DEFINES_VH
`define PSDP_DEFINES_VH

// ============================================================
// array geometry
`define PSDP_AW          18
`define PSDP_DEPTH       262144
`define PSDP_LANES       4
`define PSDP_LANE_W      9
`define PSDP_BYTE_W      8
`define PSDP_DW          32

// ============================================================
// pipeline operation codes and burst step values
`define PSDP_OP_DESEL    2'h0
`define PSDP_OP_READ     2'h1
`define PSDP_OP_WRITE    2'h2
`define PSDP_STEP_ZERO   2'h0
`define PSDP_STEP_ONE    2'h1

// ============================================================
// apb register map (byte addresses)
`define PSDP_APB_AW      12
`define PSDP_CTRL_OFF    12'h000
`define PSDP_STAT_OFF    12'h004

// ============================================================
// control register fields and reset value
`define PSDP_CTRL_USE_STRAP  0
`define PSDP_CTRL_SW_MODE    1
`define PSDP_CTRL_W          2
`define PSDP_CTRL_RESET      2'h1

// ============================================================
// status register fields
`define PSDP_STAT_DESEL      0
`define PSDP_STAT_WPHASE     1
`define PSDP_STAT_MODE       2
`define PSDP_STAT_DRIVE      3
`define PSDP_STAT_BURST_LO   4
`define PSDP_STAT_BURST_HI   5
`define PSDP_STAT_HOLD       6
`define PSDP_STAT_W          7

// ============================================================
// strap reset level: a floating strap reads as interleaved
`define PSDP_STRAP_RESET     1'h1

`endif

// file: psdp_mem.v
// byte-lane memory array with registered read data and write bypass
`timescale 1ns/1ps
`default_nettype none
`include "psdp_defines.vh"

module psdp_mem (
  // clock and reset
  input  wire                                   pclk,
  input  wire                                   presetn,
  // read port
  input  wire                                   rd_en,
  input  wire [`PSDP_AW-1:0]                    rd_addr,
  output reg  [`PSDP_LANES*`PSDP_LANE_W-1:0]    rd_data,
  // write port, one enable per lane
  input  wire [`PSDP_LANES-1:0]                 wr_en,
  input  wire [`PSDP_AW-1:0]                    wr_addr,
  input  wire [`PSDP_LANES*`PSDP_LANE_W-1:0]    wr_data
);

  // ============================================================
  // one array per lane, data byte plus its parity bit
  genvar g;
  generate
    for (g = 0; g < `PSDP_LANES; g = g + 1) begin : lane
      reg [`PSDP_LANE_W-1:0] arr [0:`PSDP_DEPTH-1];  // lane storage
      wire bypass;                                    // same-edge hit
      assign bypass = wr_en[g] & (wr_addr == rd_addr);

      // write only the lanes whose select is active
      always @(posedge pclk) begin
        if (wr_en[g]) begin
          arr[wr_addr] <= wr_data[g*`PSDP_LANE_W +: `PSDP_LANE_W];
        end
      end

      // read register holds when idle; same-edge write is
      // forwarded so read-after-write is never stale
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rd_data[g*`PSDP_LANE_W +: `PSDP_LANE_W] <= {`PSDP_LANE_W{1'b0}};
        end else if (rd_en) begin
          if (bypass) begin
            rd_data[g*`PSDP_LANE_W +: `PSDP_LANE_W] <=
              wr_data[g*`PSDP_LANE_W +: `PSDP_LANE_W];
          end else begin
            rd_data[g*`PSDP_LANE_W +: `PSDP_LANE_W] <= arr[rd_addr];
          end
        end
      end
    end
  endgenerate

endmodule // psdp_mem
`default_nettype wire

// file: psdp_apb.v
// apb slave holding the control and status registers
`timescale 1ns/1ps
`default_nettype none
`include "psdp_defines.vh"

module psdp_apb (
  // clock and reset
  input  wire                        pclk,
  input  wire                        presetn,
  // apb slave
  input  wire [`PSDP_APB_AW-1:0]     paddr,
  input  wire                        psel,
  input  wire                        penable,
  input  wire                        pwrite,
  input  wire [`PSDP_DW-1:0]         pwdata,
  output reg  [`PSDP_DW-1:0]         prdata,
  output wire                        pready,
  output reg                         pslverr,
  // block side
  output reg  [`PSDP_CTRL_W-1:0]     ctrl_reg,
  input  wire [`PSDP_STAT_W-1:0]     status
);

  // ============================================================
  // decode
  wire setup;      // first cycle of a transfer
  wire access;     // completing cycle
  wire hit_ctrl;   // control word selected
  wire hit_stat;   // status word selected
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign hit_ctrl = (paddr == `PSDP_CTRL_OFF);
  assign hit_stat = (paddr == `PSDP_STAT_OFF);
  // no wait states: data is prepared during setup
  assign pready   = 1'b1;

  // ============================================================
  // read data and error are latched at the end of setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= {`PSDP_DW{1'b0}};
      pslverr <= 1'b0;
    end else if (setup) begin
      // unmapped words read zero and flag an error
      pslverr <= ~(hit_ctrl | hit_stat);
      if (hit_ctrl) begin
        prdata <= {{(`PSDP_DW-`PSDP_CTRL_W){1'b0}}, ctrl_reg};
      end else if (hit_stat) begin
        prdata <= {{(`PSDP_DW-`PSDP_STAT_W){1'b0}}, status};
      end else begin
        prdata <= {`PSDP_DW{1'b0}};
      end
    end
  end

  // ============================================================
  // control register write, status is read only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `PSDP_CTRL_RESET;
    end else if (access & pwrite & hit_ctrl) begin
      ctrl_reg <= pwdata[`PSDP_CTRL_W-1:0];
    end
  end

endmodule // psdp_apb
`default_nettype wire

// file: psdp_core.v
// pipelined synchronous burst sram data port with apb status access
// Operation
// R1 - act only on edges with qualify low
// R2 - qualify high stretches cycle, no deselect
// R3 - capture input data on rising edge
// R4 - output data of previous read edge address
// R5 - drive only while output enable low
// R6 - float outputs in write data phase
// R7 - float first cycle after leaving deselect
// R8 - float whenever deselected
// R9 - parity lines behave as data lines
// R10 - parity lane written under its byte select
// R11 - strap high interleaved, low linear
// R12 - unconnected strap reads as interleaved
// R13 - system keeps strap fixed during operation
// R14 - byte selects active low gate writes
// R15 - burst counter wraps over two address bits
// R16 - write data captured second edge after command
// R17 - deselect floats outputs after next edge
// R18 - driver enable formed from pipeline state
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "psdp_defines.vh"

module psdp_core (
  // clock and reset
  input  wire                        pclk,
  input  wire                        presetn,
  // apb register bus
  input  wire [`PSDP_APB_AW-1:0]     paddr,
  input  wire                        psel,
  input  wire                        penable,
  input  wire                        pwrite,
  input  wire [`PSDP_DW-1:0]         pwdata,
  output wire [`PSDP_DW-1:0]         prdata,
  output wire                        pready,
  output wire                        pslverr,
  // synchronous control pins
  input  wire                        clock_qualify_n,
  input  wire                        chip_en1_n,
  input  wire                        chip_en2,
  input  wire                        chip_en3_n,
  input  wire                        write_en_n,
  input  wire                        advance_or_load,
  input  wire [`PSDP_AW-1:0]         addr,
  input  wire [`PSDP_LANES-1:0]      byte_write_sel_n,
  // output enable pin
  input  wire                        out_en_n,
  // burst order strap
  input  wire                        burst_mode,
  // data lines, split into in, out and enable
  input  wire [`PSDP_DW-1:0]         dq_in,
  output wire [`PSDP_DW-1:0]         dq_out,
  output wire                        dq_oe_n,
  // parity lines, split the same way
  input  wire [`PSDP_LANES-1:0]      parity_lines_in,
  output wire [`PSDP_LANES-1:0]      parity_lines_out,
  output wire                        parity_lines_oe_n
);

  // ============================================================
  // operation codes carried down the pipeline
  localparam [1:0] OP_DESEL = `PSDP_OP_DESEL;  // nothing selected
  localparam [1:0] OP_READ  = `PSDP_OP_READ;   // read access
  localparam [1:0] OP_WRITE = `PSDP_OP_WRITE;  // write access

  // ============================================================
  // declarations
  wire                          qual;          // edge is recognised
  wire                          selected;      // all chip enables on
  wire                          load;          // new address this edge
  wire                          mode_now;      // 1 interleaved
  wire [`PSDP_CTRL_W-1:0]       ctrl;          // software control
  wire [`PSDP_STAT_W-1:0]       status;        // state for software
  wire [`PSDP_LANES*`PSDP_LANE_W-1:0] rd_data; // registered core data
  wire [`PSDP_LANES*`PSDP_LANE_W-1:0] wr_data; // lanes from the pins
  wire [`PSDP_LANES-1:0]        wr_lane;       // per-lane write
  wire                          rd_en;         // core read strobe
  wire                          desel;         // pipeline deselected
  wire                          wphase;        // write data phase
  wire                          emerge;        // leaving deselect
  wire                          drive;         // output driver on
  reg                           strap_s1;      // strap sync stage one
  reg                           strap_s2;      // strap sync stage two
  reg  [1:0]                    burst_op_reg;  // op held for a burst
  reg  [`PSDP_AW-1:0]           base_reg;      // loaded burst address
  reg  [1:0]                    step_reg;      // accesses since load
  reg  [1:0]                    step_next;     // next burst step
  reg  [1:0]                    burst_lo;      // next low address bits
  reg  [1:0]                    op_next;       // op sampled this edge
  reg  [`PSDP_AW-1:0]           addr_next;     // address this edge
  reg  [1:0]                    s1_op_reg;     // address stage op
  reg  [`PSDP_AW-1:0]           s1_addr_reg;   // address stage word
  reg  [`PSDP_LANES-1:0]        s1_bw_reg;     // address stage selects
  reg  [1:0]                    s2_op_reg;     // data stage op
  reg  [`PSDP_AW-1:0]           s2_addr_reg;   // data stage word
  reg  [`PSDP_LANES-1:0]        s2_bw_reg;     // data stage selects

  // ============================================================
  // qualification and address-edge decode
  // clock never gated: qualify high freezes every register except the strap sync and the apb registers
  assign qual     = ~clock_qualify_n;                           // R1
  assign selected = ~chip_en1_n & chip_en2 & ~chip_en3_n;
  assign load     = ~advance_or_load;

  // ============================================================
  // strap sync, reset to the floating level
  // static board level: a change while running mixes the order
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1 <= `PSDP_STRAP_RESET;                            // R12
      strap_s2 <= `PSDP_STRAP_RESET;
    end else begin
      strap_s1 <= burst_mode;                                   // R13
      strap_s2 <= strap_s1;
    end
  end

  // software may override the strap
  assign mode_now = ctrl[`PSDP_CTRL_USE_STRAP] ? strap_s2 :
                    ctrl[`PSDP_CTRL_SW_MODE];                   // R11

  // ============================================================
  // burst counter: next step and the low address bits it yields
  always @* begin
    step_next = step_reg + `PSDP_STEP_ONE;                      // R15
    if (mode_now) begin
      // interleaved: xor with the step
      burst_lo = base_reg[1:0] ^ step_next;                     // R11
    end else begin
      // linear: add, wrap within four
      burst_lo = base_reg[1:0] + step_next;                     // R15
    end
  end

  // ============================================================
  // operation and address decided at this edge
  always @* begin
    op_next   = burst_op_reg;
    addr_next = {base_reg[`PSDP_AW-1:2], burst_lo};
    if (load) begin
      // load: enables decide the op
      addr_next = addr;
      if (!selected) begin
        op_next = OP_DESEL;
      end else if (write_en_n) begin
        op_next = OP_READ;
      end else begin
        op_next = OP_WRITE;
      end
    end
    // advance keeps the loaded op whatever the enables say
  end

  // ============================================================
  // burst state: base address, step and held operation
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_op_reg <= OP_DESEL;
      base_reg     <= {`PSDP_AW{1'b0}};
      step_reg     <= `PSDP_STEP_ZERO;
    end else if (qual) begin                                    // R2
      if (load) begin
        burst_op_reg <= op_next;
        base_reg     <= addr;
        step_reg     <= `PSDP_STEP_ZERO;
      end else begin
        step_reg     <= step_next;                              // R15
      end
    end
  end

  // ============================================================
  // two pipeline stages: address stage then data stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_op_reg   <= OP_DESEL;
      s1_addr_reg <= {`PSDP_AW{1'b0}};
      s1_bw_reg   <= {`PSDP_LANES{1'b1}};
      s2_op_reg   <= OP_DESEL;
      s2_addr_reg <= {`PSDP_AW{1'b0}};
      s2_bw_reg   <= {`PSDP_LANES{1'b1}};
    end else if (qual) begin                                    // R1
      // selects are sampled with the op, active low
      s1_op_reg   <= op_next;
      s1_addr_reg <= addr_next;
      s1_bw_reg   <= byte_write_sel_n;                          // R14
      // deselect moves down the pipe like any other op
      s2_op_reg   <= s1_op_reg;                                 // R17
      s2_addr_reg <= s1_addr_reg;
      s2_bw_reg   <= s1_bw_reg;
    end
  end

  // ============================================================
  // core access: read at the first edge, write at the second
  assign rd_en = qual & (s1_op_reg == OP_READ);                 // R4

  genvar g;
  generate
    for (g = 0; g < `PSDP_LANES; g = g + 1) begin : lane
      // each lane is a data byte with its own parity bit on top
      assign wr_data[g*`PSDP_LANE_W +: `PSDP_LANE_W] =
        {parity_lines_in[g],
         dq_in[g*`PSDP_BYTE_W +: `PSDP_BYTE_W]};               // R9
      // parity bit follows the same select as its byte
      assign wr_lane[g] = qual & (s2_op_reg == OP_WRITE) &
                          ~s2_bw_reg[g];                        // R10
      // output data straight from the read register
      assign dq_out[g*`PSDP_BYTE_W +: `PSDP_BYTE_W] =
        rd_data[g*`PSDP_LANE_W +: `PSDP_BYTE_W];               // R4
      assign parity_lines_out[g] =
        rd_data[g*`PSDP_LANE_W + `PSDP_BYTE_W];                // R9
    end
  endgenerate

  // array; its write port is the input data register
  psdp_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .rd_en   (rd_en),
    .rd_addr (s1_addr_reg),
    .rd_data (rd_data),
    .wr_en   (wr_lane),                                         // R3
    .wr_addr (s2_addr_reg),                                     // R16
    .wr_data (wr_data)
  );

  // ============================================================
  // output driver control
  // deselected: data stage holds a deselect
  assign desel  = (s2_op_reg == OP_DESEL);                      // R8
  // write data phase: controller owns the lines until capture
  assign wphase = (s2_op_reg == OP_WRITE);                      // R6
  // emerging: new op behind an idle data stage
  assign emerge = desel & (s1_op_reg != OP_DESEL);              // R7

  // out_en_n unsynchronised: it must float the bus at once
  assign drive = (s2_op_reg == OP_READ) & ~out_en_n &
                 ~wphase & ~emerge & ~desel;                    // R18
  assign dq_oe_n           = ~drive;                            // R5
  assign parity_lines_oe_n = ~drive;                            // R9

  // ============================================================
  // status word for software
  assign status[`PSDP_STAT_DESEL]    = desel;
  assign status[`PSDP_STAT_WPHASE]   = wphase;
  assign status[`PSDP_STAT_MODE]     = mode_now;
  assign status[`PSDP_STAT_DRIVE]    = drive;
  assign status[`PSDP_STAT_BURST_LO] = s1_addr_reg[0];
  assign status[`PSDP_STAT_BURST_HI] = s1_addr_reg[1];
  assign status[`PSDP_STAT_HOLD]     = clock_qualify_n;

  // ============================================================
  // register bus slave
  psdp_apb u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .paddr    (paddr),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .ctrl_reg (ctrl),
    .status   (status)
  );

endmodule // psdp_core
`default_nettype wire

// file: psdp_core_checker.sv
// checker for the sram data port output control
`timescale 1ns/1ps
`default_nettype none
`include "psdp_defines.vh"
module psdp_core_checker (
  // clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // synchronous control pins and output enable
  input wire logic                   clock_qualify_n,
  input wire logic                   chip_en1_n,
  input wire logic                   chip_en2,
  input wire logic                   chip_en3_n,
  input wire logic                   write_en_n,
  input wire logic                   advance_or_load,
  input wire logic                   out_en_n,
  // data and parity outputs
  input wire logic [`PSDP_DW-1:0]    dq_out,
  input wire logic                   dq_oe_n,
  input wire logic [`PSDP_LANES-1:0] parity_lines_out,
  input wire logic                   parity_lines_oe_n
);
  // ============================================================
  // shadow of the two pipeline stages
  wire        sel_w = !chip_en1_n && chip_en2 && !chip_en3_n; // all on
  logic [1:0] st1_reg;                  // op in address stage
  logic [1:0] st2_reg;                  // op in data stage
  // moves only on qualified edges, as the port does
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st1_reg <= `PSDP_OP_DESEL;
      st2_reg <= `PSDP_OP_DESEL;
    end else if (!clock_qualify_n) begin
      // advance beats keep the loaded op
      if (!advance_or_load) begin
        st1_reg <= !sel_w ? `PSDP_OP_DESEL :
                   write_en_n ? `PSDP_OP_READ : `PSDP_OP_WRITE;
      end
      st2_reg <= st1_reg;
    end
  end
  // ============================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_oe_gate; out_en_n |-> dq_oe_n; endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("oe ignored");
  property p_par_oe; 1'b1 |-> parity_lines_oe_n == dq_oe_n; endproperty
  a_par_oe: assert property (p_par_oe) else $error("parity oe");
  property p_rd_on; st2_reg == `PSDP_OP_READ && !out_en_n |-> !dq_oe_n;
  endproperty
  a_rd_on: assert property (p_rd_on) else $error("read not driven");
  property p_drv_src; !dq_oe_n |-> st2_reg == `PSDP_OP_READ; endproperty
  a_drv_src: assert property (p_drv_src) else $error("stray drive");
  property p_wr_flt; st2_reg == `PSDP_OP_WRITE |-> dq_oe_n; endproperty
  a_wr_flt: assert property (p_wr_flt) else $error("write drive");
  property p_ds_flt;
    !clock_qualify_n && !advance_or_load && !sel_w ##1 !clock_qualify_n
      |=> dq_oe_n;
  endproperty
  a_ds_flt: assert property (p_ds_flt) else $error("desel drive");
  property p_hold;
    clock_qualify_n |=> $stable(dq_out) && $stable(parity_lines_out);
  endproperty
  a_hold: assert property (p_hold) else $error("frozen data moved");
  property p_stretch;
    clock_qualify_n ##1 $stable(out_en_n) |-> $stable(dq_oe_n);
  endproperty
  a_stretch: assert property (p_stretch) else $error("oe moved");
endmodule // psdp_core_checker
`default_nettype wire

// file: psdp_ctl_model.sv
// controller model driving the sram data port pins
`timescale 1ns/1ps
`default_nettype none
`include "psdp_defines.vh"
module psdp_ctl_model (
  // clock and qualify
  input  wire logic                    pclk,
  input  wire logic                    clock_qualify_n,
  // control pins
  output var  logic                    chip_en1_n,
  output var  logic                    chip_en2,
  output var  logic                    chip_en3_n,
  output var  logic                    write_en_n,
  output var  logic                    advance_or_load,
  output var  logic [`PSDP_AW-1:0]     addr,
  output var  logic [`PSDP_LANES-1:0]  byte_write_sel_n,
  // shared data and parity wires
  output wire logic [`PSDP_DW-1:0]     dq_in,
  output wire logic [`PSDP_LANES-1:0]  parity_lines_in,
  input  wire logic [`PSDP_DW-1:0]     dq_out,
  input  wire logic                    dq_oe_n,
  input  wire logic [`PSDP_LANES-1:0]  parity_lines_out
);
  // ============================================================
  // beat record, read by the bench
  logic [1:0]  beat_kind = `PSDP_OP_DESEL; // op of the last beat
  logic [17:0] beat_addr = 18'h0;          // effective word address
  logic [3:0]  beat_bw   = 4'hf;           // lane selects, low active
  logic [35:0] beat_data = 36'h0;          // data for a write beat
  logic        wr1_reg   = 1'b0;           // write loaded one edge ago
  logic [35:0] wd1_reg   = 36'h0;          // its data
  logic        on_reg    = 1'b0;           // driving write data now
  logic [35:0] drv_reg   = 36'h5_a5a5_a5a5; // our side of the wires
  // device wins when it drives; else our pattern, never stale data
  assign {parity_lines_in, dq_in} = dq_oe_n ? drv_reg
                                            : {parity_lines_out, dq_out};
  // idle pins: deselected load
  initial begin
    {chip_en1_n, chip_en2, chip_en3_n} = 3'h6;
    {write_en_n, advance_or_load} = 2'h2;
    addr = 18'h0;
    byte_write_sel_n = 4'hf;
  end
  // write data for the second qualified edge
  always @(posedge pclk) begin
    if (!clock_qualify_n) begin
      wr1_reg <= (beat_kind == `PSDP_OP_WRITE);
      wd1_reg <= beat_data;
      on_reg  <= wr1_reg;
      drv_reg <= wr1_reg ? wd1_reg : ~drv_reg;
    end else if (!on_reg) begin
      // released wires keep changing
      drv_reg <= ~drv_reg;
    end
  end
  // one beat: pins set after an edge, held through the next one
  task automatic beat(input logic [1:0] k, input logic adv,
                      input logic [17:0] a, input logic [3:0] bw,
                      input logic [2:0] ce, input logic [35:0] d);
    {chip_en1_n, chip_en2, chip_en3_n} <= ce;
    write_en_n       <= (k != `PSDP_OP_WRITE);
    advance_or_load  <= adv;
    addr             <= adv ? ~a : a; // advance must not use the pins
    byte_write_sel_n <= bw;
    beat_kind <= k;
    beat_addr <= a;
    beat_bw   <= bw;
    beat_data <= d;
    @(posedge pclk);
  endtask
endmodule // psdp_ctl_model
`default_nettype wire

// file: psdp_core_tb.sv
// self-checking bench for the sram data port
`timescale 1ns/1ps
`default_nettype none
`include "psdp_defines.vh"
module psdp_core_tb;
  // ============================================================
  // pins and counters
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
  logic        penable = 1'b0, pwrite = 1'b0, burst_mode = 1'b1;
  logic        clock_qualify_n = 1'b0, out_en_n = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic        er;
  wire  logic  pready, pslverr, chip_en1_n, chip_en2, chip_en3_n;
  wire  logic  write_en_n, advance_or_load, dq_oe_n, parity_lines_oe_n;
  wire  logic [17:0] addr;
  wire  logic [3:0]  byte_write_sel_n, parity_lines_in, parity_lines_out;
  wire  logic [31:0] prdata, dq_in, dq_out;
  int          err_total = 0, comparisons = 0;
  logic [35:0] ref_mem [int];                // expected array
  logic [1:0]  k1, k2;                       // op per pipeline stage
  logic [17:0] a1, a2;
  logic [3:0]  b1, b2;
  logic [35:0] d1, d2;
  localparam logic [2:0] ON = 3'h2;          // all chip enables active
  localparam logic [1:0] RD = `PSDP_OP_READ, WR = `PSDP_OP_WRITE;
  always #5 pclk = ~pclk;
  psdp_core i_dut (.*);
  psdp_ctl_model i_ctl (.*);
  // ============================================================
  // compare, apb and burst helpers
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      summarize();
    end
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  function automatic logic [17:0] bad(logic [17:0] b, logic [1:0] s,
                                      logic m);
    return {b[17:2], m ? b[1:0] ^ s : b[1:0] + s};
  endfunction
  task automatic idle();
    repeat (3) i_ctl.beat(`PSDP_OP_DESEL, 1'b0, 18'h0, 4'hf, 3'h6, 36'h0);
  endtask
  task automatic rd1(input logic [17:0] a);
    i_ctl.beat(RD, 1'b0, a, 4'hf, ON, 36'h0);
  endtask
  // ============================================================
  // reference pipeline, writes at second edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {k1, k2} <= 4'h0;
    end else if (!clock_qualify_n) begin
      {k1, a1, b1, d1} <= {i_ctl.beat_kind, i_ctl.beat_addr,
                           i_ctl.beat_bw, i_ctl.beat_data};
      {k2, a2, b2, d2} <= {k1, a1, b1, d1};
      for (int i = 0; i < 4 && k2 == WR; i++) begin
        if (!b2[i]) ref_mem[a2][8*i+:8] <= d2[8*i+:8];
        if (!b2[i]) ref_mem[a2][32+i] <= d2[32+i];
      end
    end
  end
  // outputs judged mid-cycle, once settled
  always @(negedge pclk) begin
    if (presetn) begin
      chk(dq_oe_n, !(k2 == RD && !out_en_n));
      if (k2 == RD) chk({parity_lines_out, dq_out}, ref_mem[a2]);
    end
  end
  // ============================================================
  // test sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `PSDP_CTRL_OFF, 32'h0);
    chk(rd, `PSDP_CTRL_RESET);
    apb(1'b0, `PSDP_STAT_OFF, 32'h0);
    chk(rd[6:0], 7'h05);
    apb(1'b0, 12'h008, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
    $display("test reset done");
    i_ctl.beat(WR, 1'b0, 18'h40, 4'h0, ON, 36'h0);
    for (int i = 0; i < 4; i++) begin
      i_ctl.beat(WR, 1'b0, 18'h40, ~(4'h1 << i), ON, 36'hf_ffff_ffff);
      rd1(18'h40);
    end
    idle();
    $display("test byte lanes done");
    for (int i = 0; i < 4; i++) begin
      burst_mode <= i[0] == i[1];
      apb(1'b1, `PSDP_CTRL_OFF, {30'h0, i[1] ? {!i[0], 1'b0} : 2'h1});
      idle();
      apb(1'b0, `PSDP_STAT_OFF, 32'h0);
      chk(rd[`PSDP_STAT_MODE], !i[0]);
      for (int s = 0; s < 4; s++)
        i_ctl.beat(WR, s != 0, bad(18'h101 + 8 * i, s, rd[2]), 4'h0, ON,
                   36'h1_2345_6700 + 16 * i + s);
      for (int s = 0; s < 4; s++) rd1(bad(18'h101 + 8 * i, s, rd[2]));
      idle();
    end
    $display("test burst order done");
    rd1(18'h40);
    rd1(18'h101);
    clock_qualify_n <= 1'b1;
    apb(1'b0, `PSDP_STAT_OFF, 32'h0);
    chk(rd[`PSDP_STAT_HOLD], 1'b1);
    clock_qualify_n <= 1'b0;
    out_en_n <= 1'b1;
    rd1(18'h40);
    rd1(18'h101);
    out_en_n <= 1'b0;
    foreach (ON[j]) begin
      rd1(18'h40);
      i_ctl.beat(`PSDP_OP_DESEL, 1'b0, 18'h0, 4'hf, 3'h1 << j ^ ON, 36'h0);
      rd1(18'h101);
    end
    idle();
    $display("test stretch and deselect done");
    summarize();
  end
endmodule // psdp_core_tb
bind psdp_core psdp_core_checker i_chk (.*);
`default_nettype wire
